// File: hw/sai_pkg.sv
// Shared constants, operation codes and carriers for the store and immediate execute block.
package sai_pkg;

    // Datapath widths.
    localparam int DATA_W = 32;
    localparam int IMM_W = 16;
    localparam int REG_IDX_W = 5;
    localparam int LANES = 4;

    // Default width of the outstanding-access counter.
    localparam int OUTST_W = 4;

    // Low address bits that a full-word store must carry.
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // Half-word position of the upper-immediate load.
    localparam int UPPER_SHIFT = 16;

    // Default result word and full byte-lane mask.
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0;
    localparam logic [LANES-1:0] ALL_LANES = 4'hf;

    // Operations that this block executes; spare codes are treated as no operation.
    typedef enum logic [3:0] {
        OP_NOP,
        OP_STORE_FULL_WORD,
        OP_STORE_UNALIGNED_LEFT,
        OP_STORE_UNALIGNED_RIGHT,
        OP_SYNC,
        OP_ADD_IMM_TRAPPING,
        OP_ADD_IMM_NONTRAPPING,
        OP_SET_LESS_IMM_SIGNED,
        OP_SET_LESS_IMM_UNSIGNED,
        OP_AND_WITH_IMM,
        OP_OR_WITH_IMM,
        OP_XOR_WITH_IMM,
        OP_LOAD_UPPER_IMM
    } sai_op_t;

    // Operands of one instruction as read from the register file.
    typedef struct packed {
        logic [DATA_W-1:0] source_val;
        logic [DATA_W-1:0] target_val;
        logic [IMM_W-1:0] imm;
        logic [REG_IDX_W-1:0] target_reg_field;
    } sai_operands_t;

    // One store request toward data memory.
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] byte_en;
    } sai_mem_req_t;

    // One register write-back.
    typedef struct packed {
        logic valid;
        logic [REG_IDX_W-1:0] idx;
        logic [DATA_W-1:0] data;
    } sai_wb_t;

    localparam sai_mem_req_t MEM_REQ_RESET = '{default: '0};
    localparam sai_wb_t WB_RESET = '{default: '0};

    // Sign-extends a 16-bit field to a full word.
    function automatic logic [DATA_W-1:0] sign_ext(input logic [IMM_W-1:0] v);
        sign_ext = {{(DATA_W-IMM_W){v[IMM_W-1]}}, v};
    endfunction

    // Zero-extends a 16-bit field to a full word.
    function automatic logic [DATA_W-1:0] zero_ext(input logic [IMM_W-1:0] v);
        zero_ext = {{(DATA_W-IMM_W){1'b0}}, v};
    endfunction

endpackage

// File: hw/sai_lane_align.sv
`timescale 1ns/1ps
`default_nettype none
// Places store data on the byte lanes; lane k is bits 8k+7..8k of the memory word.
module sai_lane_align (
    input wire sai_pkg::sai_op_t op,
    input wire logic [1:0] addr_lo,
    input wire logic big_endian,
    input wire logic [sai_pkg::DATA_W-1:0] value,
    output logic [sai_pkg::DATA_W-1:0] lane_data,
    output logic [sai_pkg::LANES-1:0] byte_en,
    output logic addr_err
);
    import sai_pkg::*;

    // Byte counts of the shift; the addressed byte is lane 3-a in big endian and lane a in little endian.
    logic [1:0] left_shift_bytes;
    logic [1:0] right_shift_bytes;

    assign left_shift_bytes = big_endian ? addr_lo : ~addr_lo; // RQ17 RQ18
    assign right_shift_bytes = big_endian ? ~addr_lo : addr_lo; // RQ17 RQ18

    // Lane steering per store kind; the left and right pair together cover all four bytes, each once except on a word-aligned pair, where both write all four.
    always_comb begin
        lane_data = value;
        byte_en = ALL_LANES;
        addr_err = 1'b0;
        unique case (op)
            OP_STORE_FULL_WORD: begin
                addr_err = (addr_lo != WORD_ALIGN); // RQ16
            end
            OP_STORE_UNALIGNED_LEFT: begin
                lane_data = value >> {left_shift_bytes, 3'h0}; // RQ3 RQ4 RQ5
                byte_en = ALL_LANES >> left_shift_bytes; // RQ5 RQ18
            end
            OP_STORE_UNALIGNED_RIGHT: begin
                lane_data = value << {right_shift_bytes, 3'h0}; // RQ3 RQ4 RQ6
                byte_en = ALL_LANES << right_shift_bytes; // RQ6 RQ18
            end
            default: begin
                // Not a store: lanes are unused.
                addr_err = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// File: hw/sai_store_imm_alu.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1: Store address is base plus sign-extended offset.
// RQ2: Full-word store writes the target register word.
// RQ3: Left and right stores pair across boundary.
// RQ4: Left writes left part, right writes right.
// RQ5: Left store shifts right, writes original lanes.
// RQ6: Right store shifts left, writes original lanes.
// RQ7: Sync stalls until earlier accesses complete.
// RQ8: Immediate ops use register and 16-bit field.
// RQ9: Trapping add sign-extends, adds, writes target.
// RQ10: Trapping add raises exception on overflow.
// RQ11: Non-trapping add never raises overflow exception.
// RQ12: Signed compare against sign-extended immediate.
// RQ13: Unsigned compare, immediate still sign-extended.
// RQ14: Logic ops use zero-extended immediate.
// RQ15: Upper load places immediate high, clears low.
// RQ16: Misaligned full-word store raises address error.
// RQ17: Address names lowest byte, endian sets lane.
// RQ18: Partial-store lanes follow address and endianness.
// RQ19: Overflowing trapping add leaves target unchanged.
// RQ20: Address addition wraps, never traps.
module sai_store_imm_alu #(
    parameter int OUTST_WIDTH = sai_pkg::OUTST_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    input wire sai_pkg::sai_op_t in_op,
    input wire sai_pkg::sai_operands_t in_opnd,
    input wire logic big_endian,
    input wire logic load_issue,
    input wire logic mem_ready,
    input wire logic mem_done,
    output logic stall,
    output sai_pkg::sai_mem_req_t mem_req,
    output sai_pkg::sai_wb_t wb,
    output logic trap_overflow,
    output logic trap_addr_error
);
    import sai_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic accept; // Instruction taken this cycle.
    logic is_store; // Current instruction is one of the three stores.
    logic mem_hold; // A store is waiting for memory to take it.
    logic [DATA_W-1:0] imm_sext; // Immediate, sign-extended.
    logic [DATA_W-1:0] imm_zext; // Immediate, zero-extended.
    logic [DATA_W-1:0] eff_addr; // Store effective address.
    logic [DATA_W-1:0] add_sum; // Register plus sign-extended immediate.
    logic add_ovf; // Two's-complement overflow of add_sum.
    logic [DATA_W-1:0] alu_result; // Value for the target register.
    logic alu_write; // Instruction writes the target register.
    logic [DATA_W-1:0] lane_data; // Store data placed on lanes.
    logic [LANES-1:0] lane_en; // Store byte enables.
    logic lane_addr_err; // Store address not allowed for its size.
    logic [OUTST_WIDTH-1:0] outst_reg; // Loads and stores not yet complete.
    logic [OUTST_WIDTH-1:0] outst_next;
    sai_mem_req_t mem_req_reg;
    sai_wb_t wb_reg;
    logic trap_ovf_reg;
    logic trap_addr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Issue control.

    // A pending store holds every instruction, so memory order is kept and a
    // store never overtakes the one ahead of it.
    assign mem_hold = mem_req_reg.valid && !mem_ready;
    // Sync waits while the counter shows any access in flight.
    assign stall = mem_hold || (in_valid && in_op == OP_SYNC && outst_reg != '0); // RQ7
    assign accept = in_valid && !stall;
    assign is_store = in_op inside {OP_STORE_FULL_WORD, OP_STORE_UNALIGNED_LEFT, OP_STORE_UNALIGNED_RIGHT};

    ////////////////////////////////////////////////////////////////////////////
    // Address and arithmetic.

    assign imm_sext = sign_ext(in_opnd.imm); // RQ8 RQ9
    assign imm_zext = zero_ext(in_opnd.imm); // RQ14
    // The offset field shares the immediate position; the sum simply wraps.
    assign eff_addr = in_opnd.source_val + imm_sext; // RQ1 RQ20
    assign add_sum = in_opnd.source_val + imm_sext; // RQ9
    // Overflow when both addends share a sign the sum does not.
    assign add_ovf = (in_opnd.source_val[DATA_W-1] == imm_sext[DATA_W-1]) &&
                     (add_sum[DATA_W-1] != in_opnd.source_val[DATA_W-1]); // RQ10

    // Result selection for the immediate group.
    always_comb begin
        alu_result = ZERO_WORD;
        alu_write = 1'b1;
        unique case (in_op)
            OP_ADD_IMM_TRAPPING: begin
                alu_result = add_sum; // RQ9
                alu_write = !add_ovf; // RQ19
            end
            OP_ADD_IMM_NONTRAPPING: begin
                alu_result = add_sum; // RQ11
            end
            OP_SET_LESS_IMM_SIGNED: begin
                alu_result = {{(DATA_W-1){1'b0}}, $signed(in_opnd.source_val) < $signed(imm_sext)}; // RQ12
            end
            OP_SET_LESS_IMM_UNSIGNED: begin
                alu_result = {{(DATA_W-1){1'b0}}, in_opnd.source_val < imm_sext}; // RQ13
            end
            OP_AND_WITH_IMM: begin
                alu_result = in_opnd.source_val & imm_zext; // RQ14
            end
            OP_OR_WITH_IMM: begin
                alu_result = in_opnd.source_val | imm_zext; // RQ14
            end
            OP_XOR_WITH_IMM: begin
                alu_result = in_opnd.source_val ^ imm_zext; // RQ14
            end
            OP_LOAD_UPPER_IMM: begin
                alu_result = imm_zext << UPPER_SHIFT; // RQ15
            end
            default: begin
                // Stores, sync, no-op and spare codes write nothing.
                alu_write = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Store lane placement.

    sai_lane_align u_lane (
        .op(in_op),
        .addr_lo(eff_addr[1:0]),
        .big_endian(big_endian),
        .value(in_opnd.target_val),
        .lane_data(lane_data),
        .byte_en(lane_en),
        .addr_err(lane_addr_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Store request: loaded on accept, held until memory takes it.
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_req_reg <= MEM_REQ_RESET;
        end else if (accept && is_store && !lane_addr_err) begin
            mem_req_reg.valid <= 1'b1; // RQ2 RQ16
            mem_req_reg.addr <= eff_addr; // RQ1
            mem_req_reg.data <= lane_data; // RQ2
            mem_req_reg.byte_en <= lane_en; // RQ18
        end else if (mem_ready) begin
            mem_req_reg.valid <= 1'b0;
        end
    end

    // Write-back: one-cycle valid, the value held until the next result.
    always_ff @(posedge clock) begin
        if (rst) begin
            wb_reg <= WB_RESET;
        end else begin
            wb_reg.valid <= accept && alu_write; // RQ19
            if (accept && alu_write) begin
                wb_reg.idx <= in_opnd.target_reg_field;
                wb_reg.data <= alu_result;
            end
        end
    end

    // Exception pulses; the non-trapping add never reaches the overflow term.
    always_ff @(posedge clock) begin
        if (rst) begin
            trap_ovf_reg <= 1'b0;
            trap_addr_reg <= 1'b0;
        end else begin
            trap_ovf_reg <= accept && in_op == OP_ADD_IMM_TRAPPING && add_ovf; // RQ10 RQ11
            trap_addr_reg <= accept && lane_addr_err; // RQ16
        end
    end

    // Counts stores from issue and loads from their issue pulse until the
    // completion pulse. The counter does not saturate, so the pipeline must
    // keep fewer than 2**OUTST_WIDTH accesses in flight.
    always_comb begin
        outst_next = outst_reg;
        if (accept && is_store && !lane_addr_err) begin
            outst_next = outst_next + 1'b1;
        end
        if (load_issue) begin
            outst_next = outst_next + 1'b1;
        end
        if (mem_done) begin
            outst_next = outst_next - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            outst_reg <= '0;
        end else begin
            outst_reg <= outst_next; // RQ7
        end
    end

    assign mem_req = mem_req_reg;
    assign wb = wb_reg;
    assign trap_overflow = trap_ovf_reg;
    assign trap_addr_error = trap_addr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    store_addr_a: assert property (accept && is_store && !lane_addr_err |=> // RQ1
        mem_req.valid && mem_req.addr == $past(eff_addr)) else $error("store address wrong");
    full_word_a: assert property (accept && in_op == OP_STORE_FULL_WORD && eff_addr[1:0] == WORD_ALIGN |=> // RQ2
        mem_req.data == $past(in_opnd.target_val) && mem_req.byte_en == ALL_LANES)
        else $error("full word store wrong");
    misalign_err_a: assert property (accept && in_op == OP_STORE_FULL_WORD && eff_addr[1:0] != WORD_ALIGN |=> // RQ16
        trap_addr_error && !mem_req.valid) else $error("misaligned store not refused");
    left_lanes_a: assert property (accept && in_op == OP_STORE_UNALIGNED_LEFT && big_endian |=> // RQ5
        mem_req.byte_en == (ALL_LANES >> $past(eff_addr[1:0]))) else $error("left store lanes wrong");
    right_lanes_a: assert property (accept && in_op == OP_STORE_UNALIGNED_RIGHT && !big_endian |=> // RQ6
        mem_req.byte_en == (ALL_LANES << $past(eff_addr[1:0]))) else $error("right store lanes wrong");
    sync_hold_a: assert property (in_valid && in_op == OP_SYNC && outst_reg != '0 |-> stall) // RQ7
        else $error("sync not stalled");
    sync_release_a: assert property (in_valid && in_op == OP_SYNC && outst_reg == '0 && !mem_req.valid |-> // RQ7
        !stall) else $error("sync stalled needlessly");
    ovf_trap_a: assert property (accept && in_op == OP_ADD_IMM_TRAPPING && add_ovf |=> // RQ10
        trap_overflow && !wb.valid) else $error("overflow not trapped");
    nontrap_add_a: assert property (accept && in_op == OP_ADD_IMM_NONTRAPPING |=> // RQ11
        wb.valid && !trap_overflow &&
        wb.data == $past(in_opnd.source_val) + {{(DATA_W-IMM_W){$past(in_opnd.imm[IMM_W-1])}}, $past(in_opnd.imm)})
        else $error("non-trapping add wrong");
    slt_signed_a: assert property (accept && in_op == OP_SET_LESS_IMM_SIGNED |=> // RQ12
        wb.data[DATA_W-1:1] == '0 && wb.valid) else $error("signed compare result wide");
    logic_imm_a: assert property (accept && in_op == OP_AND_WITH_IMM |=> // RQ14
        wb.data[DATA_W-1:IMM_W] == '0) else $error("and immediate not zero-extended");
    upper_imm_a: assert property (accept && in_op == OP_LOAD_UPPER_IMM |=> // RQ15
        wb.data == {$past(in_opnd.imm), 16'h0}) else $error("upper immediate wrong");

    sync_wait_c: cover property (in_valid && in_op == OP_SYNC && stall ##1 !stall);
    left_right_c: cover property (accept && in_op == OP_STORE_UNALIGNED_LEFT ##1
        accept && in_op == OP_STORE_UNALIGNED_RIGHT);
    overflow_c: cover property (trap_overflow);
    mem_backpressure_c: cover property (mem_req.valid && !mem_ready ##1 mem_req.valid && mem_ready);
endmodule
`default_nettype wire

// File: verif/sai_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural data memory and pipeline control on the far side of the execute block.
module sai_mem_model (
    input wire logic clock,
    input wire logic rst,
    input wire sai_pkg::sai_mem_req_t mem_req,
    input wire logic load_issue,
    input wire logic [3:0] lat,
    output logic mem_ready,
    output logic mem_done
);
    import sai_pkg::*;
    logic [3:0] wait_reg; // Cycles the current request has waited so far.
    logic [7:0] done_reg; // One bit per cycle of the completion delay; accesses taken in the same cycle share one bit.

    ////////////////////////////////////////////////////////////////////////
    // Acceptance waits lat cycles, so a zero makes the memory prompt and a larger value slow.
    always_ff @(posedge clock) begin
        if (rst || !mem_req.valid || mem_ready) begin
            wait_reg <= 4'h0;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
    assign mem_ready = mem_req.valid && (wait_reg >= lat);

    ////////////////////////////////////////////////////////////////////////
    // Each taken store or issued load completes a fixed eight cycles later.
    // A store and a load in the same cycle would merge; the bench never does that.
    always_ff @(posedge clock) begin
        if (rst) begin
            done_reg <= 8'h0;
        end else begin
            done_reg <= {done_reg[6:0], (mem_req.valid && mem_ready) || load_issue};
        end
    end
    assign mem_done = done_reg[7];
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the store and immediate execute block.
module tb_top;
    import sai_pkg::*;
    logic clock = 1'b0; // Core clock, 50 ns period.
    logic rst = 1'b1; // Synchronous reset, held for 20 cycles.
    logic in_valid = 1'b0; // Instruction present.
    sai_op_t in_op = OP_NOP; // Operation under test.
    sai_operands_t in_opnd = '0; // Register and immediate operands.
    logic big_endian = 1'b0; // Lane mapping select.
    logic load_issue = 1'b0; // Load pulse from elsewhere in the pipeline.
    logic [3:0] lat = 4'h0; // Memory acceptance delay.
    logic mem_ready, mem_done, stall, trap_overflow, trap_addr_error;
    sai_mem_req_t mem_req;
    sai_wb_t wb;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    logic done_seen = 1'b0; // Set whenever a completion arrives.

    always #25 clock = ~clock;

    sai_store_imm_alu sai_store_imm_alu_i (.clock(clock), .rst(rst), .in_valid(in_valid), .in_op(in_op),
        .in_opnd(in_opnd), .big_endian(big_endian), .load_issue(load_issue), .mem_ready(mem_ready),
        .mem_done(mem_done), .stall(stall), .mem_req(mem_req), .wb(wb), .trap_overflow(trap_overflow),
        .trap_addr_error(trap_addr_error));
    sai_mem_model sai_mem_model_i (.clock(clock), .rst(rst), .mem_req(mem_req), .load_issue(load_issue),
        .lat(lat), .mem_ready(mem_ready), .mem_done(mem_done));

    ////////////////////////////////////////////////////////////////////////
    // A hang counts as a mismatch; the whole run needs well under this many cycles.
    always @(posedge clock) begin
        cycles++;
        if (mem_done === 1'b1) begin
            done_seen = 1'b1;
        end
        if (cycles == 3000) begin
            fails++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the instruction until the block stops stalling, then returns just after the taking edge.
    task automatic issue(input sai_op_t op, input logic [31:0] src, input logic [31:0] tgt, input logic [15:0] imm);
        int n;
        n = 0;
        // One edge passes first, so the last call's release never meets this request in one time step.
        @(posedge clock);
        #1;
        in_valid = 1'b1;
        in_op = op;
        in_opnd = '{src, tgt, imm, 5'h07};
        // The stall term is combinational; give it time to see the new request before it is read.
        #1;
        while (stall !== 1'b0 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(32'(stall), 32'h0);
        @(posedge clock);
        #1;
        in_valid = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One immediate operation; a trapping case must give the pulse and no write-back.
    task automatic imm_case(input sai_op_t op, input logic [31:0] src, input logic [15:0] imm,
        input logic [31:0] exp, input logic trap);
        issue(op, src, 32'h0, imm);
        check(32'(wb.valid), 32'(!trap));
        check(32'(trap_overflow), 32'(trap));
        if (!trap) begin
            check(32'(wb.idx), 32'h7);
            check(wb.data, exp);
        end
    endtask

    task automatic test_imm();
        imm_case(OP_ADD_IMM_TRAPPING, 32'h5, 16'hffff, 32'h4, 1'b0);
        imm_case(OP_ADD_IMM_TRAPPING, 32'h7fffffff, 16'h0001, 32'h0, 1'b1);
        imm_case(OP_ADD_IMM_TRAPPING, 32'h80000000, 16'hffff, 32'h0, 1'b1);
        imm_case(OP_ADD_IMM_NONTRAPPING, 32'h7fffffff, 16'h0001, 32'h80000000, 1'b0);
        imm_case(OP_SET_LESS_IMM_SIGNED, 32'hffffffff, 16'h0000, 32'h1, 1'b0);
        imm_case(OP_SET_LESS_IMM_SIGNED, 32'h1, 16'hffff, 32'h0, 1'b0);
        imm_case(OP_SET_LESS_IMM_UNSIGNED, 32'h1, 16'hffff, 32'h1, 1'b0);
        imm_case(OP_SET_LESS_IMM_UNSIGNED, 32'hffffffff, 16'h0001, 32'h0, 1'b0);
        imm_case(OP_AND_WITH_IMM, 32'hffffffff, 16'h8001, 32'h8001, 1'b0);
        imm_case(OP_OR_WITH_IMM, 32'h12340000, 16'h8000, 32'h12348000, 1'b0);
        imm_case(OP_XOR_WITH_IMM, 32'hffff0000, 16'hffff, 32'hffffffff, 1'b0);
        imm_case(OP_LOAD_UPPER_IMM, 32'hffffffff, 16'h8765, 32'h87650000, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One store; fields are read before the memory takes them since they stand until then.
    task automatic store_case(input sai_op_t op, input logic be, input logic [31:0] base, input logic [15:0] off,
        input logic [31:0] val, input logic [31:0] exp_d, input logic [3:0] exp_en, input logic err);
        big_endian = be;
        issue(op, base, val, off);
        check(32'(mem_req.valid), 32'(!err));
        check(32'(trap_addr_error), 32'(err));
        if (!err) begin
            check(mem_req.addr, base + {{16{off[15]}}, off});
            check(mem_req.data, exp_d);
            check(32'(mem_req.byte_en), 32'(exp_en));
        end
    endtask

    task automatic test_store();
        int sh;
        lat = 4'h2;
        store_case(OP_STORE_FULL_WORD, 1'b0, 32'hfffffff0, 16'h0020, 32'ha5a5c3c3, 32'ha5a5c3c3, 4'hf, 1'b0);
        store_case(OP_STORE_FULL_WORD, 1'b1, 32'h100, 16'hfffc, 32'h01020304, 32'h01020304, 4'hf, 1'b0);
        for (int a = 1; a < 4; a++) begin
            store_case(OP_STORE_FULL_WORD, 1'b0, 32'h100, 16'(a), 32'h1, 32'h0, 4'h0, 1'b1);
        end
        for (int e = 0; e < 2; e++) begin
            for (int a = 0; a < 4; a++) begin
                sh = (e == 1) ? a : 3 - a;
                store_case(OP_STORE_UNALIGNED_LEFT, e[0], 32'h1000, 16'(a), 32'h11223344,
                    32'h11223344 >> (8 * sh), 4'hf >> sh, 1'b0);
                sh = (e == 1) ? 3 - a : a;
                store_case(OP_STORE_UNALIGNED_RIGHT, e[0], 32'h1000, 16'(a), 32'h11223344,
                    32'h11223344 << (8 * sh), 4'hf << sh, 1'b0);
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Sync right behind a slow store, then behind a load, must wait for the completion.
    task automatic test_sync();
        lat = 4'h3;
        repeat (20) @(posedge clock);
        #1;
        done_seen = 1'b0;
        store_case(OP_STORE_FULL_WORD, 1'b0, 32'h200, 16'h0, 32'hcafe0001, 32'hcafe0001, 4'hf, 1'b0);
        issue(OP_SYNC, 32'h0, 32'h0, 16'h0);
        check(32'(done_seen), 32'h1);
        check(32'(wb.valid), 32'h0);
        done_seen = 1'b0;
        load_issue = 1'b1;
        @(posedge clock);
        #1;
        load_issue = 1'b0;
        issue(OP_SYNC, 32'h0, 32'h0, 16'h0);
        check(32'(done_seen), 32'h1);
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clock);
        #1;
        rst = 1'b0;
        test_imm();
        test_store();
        test_sync();
        finish_test();
    end
endmodule
`default_nettype wire
